// *** verilog/rssi_pwm_output.sv ***
/*
 * Signal strength and passed-value pulse outputs with their hold and timeout
 * timers, plus the parameters written over the serial command path.
 * Assumes packet strobes, margin and passed samples come from logic on mclk.
 */
// Behaviour
// - One 8-bit passed-value timeout, 100 ms units, shared by both outputs.
// - Non-zero passed value starts the timer; expiry forces zero duty.
// - A valid I/O packet with a non-zero value restarts the passed-value timer; an all-zero one stops it.
// - Passed-value timeout resets to 0xFF.
// - Output period is fixed at 64 us.
// - Period split into 445 steps of 144 ns.
// - Above sensitivity, duty 24 to 100 percent rising with margin.
// - At or below sensitivity, duty 1 to 24 percent.
// - Zero duty only when the signal strength output is inactive.
// - 10, 20, 30 dB margin give 41, 58, 75 percent.
// - Hold 0x01 to 0xFE shows last strength that long, then zero duty.
// - Zero duty from power-up until the first packet arrives.
// - Hold value 0xFF never times out the strength output.
// - Strength hold setting resets to 0x28.
// - Per-pin function select: 0 off, 1 strength, 2 passed value.
`default_nettype none

module rssi_pwm_output #(
    parameter int TICK_CYCLES = rssi_pwm_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Parameter command path
    input wire logic cmd_wr,
    input wire logic [2:0] cmd_sel,
    input wire logic [7:0] cmd_wdata,
    input wire logic [2:0] cmd_rd_sel,
    output logic [7:0] cmd_rdata,
    // Received radio packet
    input wire logic rx_pkt_valid,
    input wire logic signed [7:0] rx_margin_db,
    // I/O line passing packet
    input wire logic io_pkt_valid,
    input wire logic [9:0] io_value0,
    input wire logic [9:0] io_value1,
    // Pulse outputs
    output logic pulse_output_zero,
    output logic pulse_output_one
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta_q, rst_sync_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [23:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;
    logic [7:0] pwm_output_timeout_q, pwm_output_timeout_d;
    logic [7:0] signal_strength_hold_time_q, signal_strength_hold_time_d;
    logic [1:0] pulse_output_zero_function_q, pulse_output_zero_function_d;
    logic [1:0] pulse_output_one_function_q, pulse_output_one_function_d;
    logic rssi_seen_q, rssi_seen_d;
    logic rssi_live_q, rssi_live_d;
    logic [8:0] rssi_duty_q, rssi_duty_d;
    logic [7:0] hold_cnt_q, hold_cnt_d;
    logic [8:0] pass_duty0_q, pass_duty0_d, pass_duty1_q, pass_duty1_d;
    logic [7:0] pass_cnt_q, pass_cnt_d;
    logic [7:0] rdata_d;
    logic [8:0] in_duty0, in_duty1;

    pwm_duty_if pwm ();

    assign in_duty0 = rssi_pwm_pkg::scale_passed(io_value0);
    assign in_duty1 = rssi_pwm_pkg::scale_passed(io_value1);

    function automatic logic [8:0] select_duty(input logic [1:0] func,
                                               input logic [8:0] passed);
        unique case (func)
            rssi_pwm_pkg::FUNC_RSSI: select_duty = rssi_live_q ? rssi_duty_q : 9'h000;
            rssi_pwm_pkg::FUNC_PASSED: select_duty = passed;
            default: select_duty = 9'h000;
        endcase
    endfunction : select_duty

    always_comb begin
        // 100 ms time base
        tick_d = 1'b0;
        tick_cnt_d = tick_cnt_q + 24'h000001;
        if (tick_cnt_q == 24'(TICK_CYCLES - 1)) begin
            tick_cnt_d = 24'h000000;
            tick_d = 1'b1;
        end

        // Parameter writes; an out-of-range function code is ignored
        pwm_output_timeout_d = pwm_output_timeout_q;
        signal_strength_hold_time_d = signal_strength_hold_time_q;
        pulse_output_zero_function_d = pulse_output_zero_function_q;
        pulse_output_one_function_d = pulse_output_one_function_q;
        if (cmd_wr) begin
            unique case (cmd_sel)
                rssi_pwm_pkg::SEL_TIMEOUT: pwm_output_timeout_d = cmd_wdata;
                rssi_pwm_pkg::SEL_HOLD: signal_strength_hold_time_d = cmd_wdata;
                rssi_pwm_pkg::SEL_FUNC0: if (cmd_wdata <= 8'(rssi_pwm_pkg::FUNC_PASSED)) begin
                    pulse_output_zero_function_d = cmd_wdata[1:0];
                end
                rssi_pwm_pkg::SEL_FUNC1: if (cmd_wdata <= 8'(rssi_pwm_pkg::FUNC_PASSED)) begin
                    pulse_output_one_function_d = cmd_wdata[1:0];
                end
                default: ;
            endcase
        end

        // Signal strength hold; a new packet wins over expiry in the same cycle
        rssi_seen_d = rssi_seen_q;
        rssi_live_d = rssi_live_q;
        rssi_duty_d = rssi_duty_q;
        hold_cnt_d = hold_cnt_q;
        if (rx_pkt_valid) begin
            rssi_seen_d = 1'b1;
            rssi_duty_d = rssi_pwm_pkg::rssi_to_duty(rx_margin_db);
            hold_cnt_d = signal_strength_hold_time_q;
            rssi_live_d = signal_strength_hold_time_q != 8'h00;
        end else if (tick_q && rssi_live_q
                     && signal_strength_hold_time_q != rssi_pwm_pkg::HOLD_FOREVER) begin
            hold_cnt_d = hold_cnt_q - 8'h01;
            if (hold_cnt_q <= 8'h01) begin
                hold_cnt_d = 8'h00;
                rssi_live_d = 1'b0;
            end
        end

        // Passed values; a valid packet with a non-zero value restarts the shared timer, else stops it
        pass_duty0_d = pass_duty0_q;
        pass_duty1_d = pass_duty1_q;
        pass_cnt_d = pass_cnt_q;
        if (io_pkt_valid) begin
            pass_duty0_d = in_duty0;
            pass_duty1_d = in_duty1;
            if (in_duty0 != 9'h000 || in_duty1 != 9'h000) begin
                pass_cnt_d = pwm_output_timeout_q;
            end else begin
                pass_cnt_d = 8'h00;
            end
        end else if (tick_q && pass_cnt_q != 8'h00) begin
            pass_cnt_d = pass_cnt_q - 8'h01;
            if (pass_cnt_q == 8'h01) begin
                pass_duty0_d = 9'h000;
                pass_duty1_d = 9'h000;
            end
        end

        // Read-back
        unique case (cmd_rd_sel)
            rssi_pwm_pkg::SEL_TIMEOUT: rdata_d = pwm_output_timeout_q;
            rssi_pwm_pkg::SEL_HOLD: rdata_d = signal_strength_hold_time_q;
            rssi_pwm_pkg::SEL_FUNC0: rdata_d = {6'h00, pulse_output_zero_function_q};
            rssi_pwm_pkg::SEL_FUNC1: rdata_d = {6'h00, pulse_output_one_function_q};
            rssi_pwm_pkg::SEL_STATUS: begin
                rdata_d = 8'h00;
                rdata_d[rssi_pwm_pkg::ST_PASS_RUN] = pass_cnt_q != 8'h00;
                rdata_d[rssi_pwm_pkg::ST_RSSI_LIVE] = rssi_live_q;
                rdata_d[rssi_pwm_pkg::ST_RSSI_SEEN] = rssi_seen_q;
            end
            default: rdata_d = 8'h00;
        endcase

        pwm.duty0 = select_duty(pulse_output_zero_function_q, pass_duty0_q);
        pwm.duty1 = select_duty(pulse_output_one_function_q, pass_duty1_q);
    end

    always_ff @(posedge mclk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            tick_cnt_q <= 24'h000000;
            tick_q <= 1'b0;
            pwm_output_timeout_q <= rssi_pwm_pkg::TIMEOUT_RST;
            signal_strength_hold_time_q <= rssi_pwm_pkg::HOLD_RST;
            pulse_output_zero_function_q <= rssi_pwm_pkg::FUNC0_RST;
            pulse_output_one_function_q <= rssi_pwm_pkg::FUNC1_RST;
            rssi_seen_q <= 1'b0;
            rssi_live_q <= 1'b0;
            rssi_duty_q <= 9'h000;
            hold_cnt_q <= 8'h00;
            pass_duty0_q <= 9'h000;
            pass_duty1_q <= 9'h000;
            pass_cnt_q <= 8'h00;
            cmd_rdata <= 8'h00;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            pwm_output_timeout_q <= pwm_output_timeout_d;
            signal_strength_hold_time_q <= signal_strength_hold_time_d;
            pulse_output_zero_function_q <= pulse_output_zero_function_d;
            pulse_output_one_function_q <= pulse_output_one_function_d;
            rssi_seen_q <= rssi_seen_d;
            rssi_live_q <= rssi_live_d;
            rssi_duty_q <= rssi_duty_d;
            hold_cnt_q <= hold_cnt_d;
            pass_duty0_q <= pass_duty0_d;
            pass_duty1_q <= pass_duty1_d;
            pass_cnt_q <= pass_cnt_d;
            cmd_rdata <= rdata_d;
        end
    end

    pwm_wave_gen wave_gen (
        .mclk(mclk),
        .rst_n(rst_sync_q),
        .pwm(pwm.gen)
    );

    assign pulse_output_zero = pwm.wave0;
    assign pulse_output_one = pwm.wave1;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_sync_q);

    sequence s_pass_last_tick;
        tick_q && pass_cnt_q == 8'h01 && !io_pkt_valid;
    endsequence

    sequence s_rssi_last_tick;
        tick_q && rssi_live_q && hold_cnt_q == 8'h01 && !rx_pkt_valid
            && signal_strength_hold_time_q != rssi_pwm_pkg::HOLD_FOREVER;
    endsequence

    a_reset_timeout: assert property ($rose(rst_sync_q) |->
        pwm_output_timeout_q == rssi_pwm_pkg::TIMEOUT_RST)
        else $error("passed timeout not 0xFF after reset");

    a_reset_hold: assert property ($rose(rst_sync_q) |->
        signal_strength_hold_time_q == rssi_pwm_pkg::HOLD_RST)
        else $error("strength hold not 0x28 after reset");

    a_tick_spacing: assert property (tick_q |=> !tick_q)
        else $error("100 ms ticks back to back");

    a_pass_restart: assert property (io_pkt_valid
        && (in_duty0 != 9'h000 || in_duty1 != 9'h000)
        |=> pass_cnt_q == $past(pwm_output_timeout_q))
        else $error("passed timer not restarted by I/O packet");

    a_pass_expire: assert property (s_pass_last_tick |=>
        pass_duty0_q == 9'h000 && pass_duty1_q == 9'h000 && pass_cnt_q == 8'h00)
        else $error("passed outputs not cleared at expiry");

    a_rssi_load: assert property (rx_pkt_valid && signal_strength_hold_time_q != 8'h00
        |=> rssi_live_q && rssi_duty_q == rssi_pwm_pkg::rssi_to_duty($past(rx_margin_db)))
        else $error("strength duty not taken from packet");

    a_rssi_expire: assert property (s_rssi_last_tick |=> !rssi_live_q)
        else $error("strength output not dropped after hold");

    a_rssi_forever: assert property (rssi_live_q && !rx_pkt_valid
        && signal_strength_hold_time_q == rssi_pwm_pkg::HOLD_FOREVER |=> rssi_live_q)
        else $error("strength output timed out with hold 0xFF");

    a_rssi_first: assert property (!rssi_seen_q |-> !rssi_live_q)
        else $error("strength output live before first packet");

    a_func_off: assert property (pulse_output_zero_function_q == rssi_pwm_pkg::FUNC_DISABLED
        |-> pwm.duty0 == 9'h000)
        else $error("disabled output has non-zero duty");

    a_duty_range: assert property (rssi_live_q |-> rssi_duty_q >= rssi_pwm_pkg::DUTY_MIN
        && rssi_duty_q <= rssi_pwm_pkg::DUTY_MAX)
        else $error("live strength duty outside 1..100 percent");

endmodule : rssi_pwm_output

`default_nettype wire

// *** verilog/rssi_pwm_pkg.sv ***
/*
 * Constants shared by the signal strength / passed-value pulse output block:
 * timing counts, reset values, parameter select codes and duty arithmetic.
 * Assumes a single 100 MHz clock.
 */
`default_nettype none

package rssi_pwm_pkg;

    // Clock and timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int PERIOD_NS = 64_000;
    localparam int STEP_NS = 144;
    localparam int PWM_STEPS = 445;
    localparam int PERIOD_CYCLES = (CLK_FREQ_HZ / 1_000_000) * PERIOD_NS / 1000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1000) * TICK_MS;

    // Parameter select codes of the command port
    localparam logic [2:0] SEL_TIMEOUT = 3'h0;
    localparam logic [2:0] SEL_HOLD = 3'h1;
    localparam logic [2:0] SEL_FUNC0 = 3'h2;
    localparam logic [2:0] SEL_FUNC1 = 3'h3;
    localparam logic [2:0] SEL_STATUS = 3'h4;

    // Output function codes
    localparam logic [1:0] FUNC_DISABLED = 2'h0;
    localparam logic [1:0] FUNC_RSSI = 2'h1;
    localparam logic [1:0] FUNC_PASSED = 2'h2;

    // Reset values
    localparam logic [7:0] TIMEOUT_RST = 8'hFF;
    localparam logic [7:0] HOLD_RST = 8'h28;
    localparam logic [1:0] FUNC0_RST = 2'h1;
    localparam logic [1:0] FUNC1_RST = 2'h0;
    localparam logic [7:0] HOLD_FOREVER = 8'hFF;

    // Status bit positions
    localparam int ST_PASS_RUN = 0;
    localparam int ST_RSSI_LIVE = 1;
    localparam int ST_RSSI_SEEN = 2;

    // Duty arithmetic, in thousandths of a step
    localparam int MILLI = 1000;
    localparam int DUTY_OFFSET_MILLI = 106_800;
    localparam int DUTY_SLOPE_MILLI = 7_565;
    localparam int DUTY_ROUND_MILLI = 500;
    localparam logic [8:0] DUTY_MIN = 9'h005;
    localparam logic [8:0] DUTY_MAX = 9'h1BD;
    localparam int PASS_FULL = 1023;

    // 24 % at sensitivity, +1.7 % per dB, clamped to 1 % .. 100 %
    function automatic logic [8:0] rssi_to_duty(input logic signed [7:0] margin);
        int v;
        v = DUTY_OFFSET_MILLI + DUTY_SLOPE_MILLI * int'(margin) + DUTY_ROUND_MILLI;
        if (v < int'(DUTY_MIN) * MILLI) begin
            rssi_to_duty = DUTY_MIN;
        end else if (v / MILLI > int'(DUTY_MAX)) begin
            rssi_to_duty = DUTY_MAX;
        end else begin
            rssi_to_duty = 9'(v / MILLI);
        end
    endfunction : rssi_to_duty

    // Full-scale passed sample maps to 100 %, rounded to nearest step
    function automatic logic [8:0] scale_passed(input logic [9:0] val);
        scale_passed = 9'((int'(val) * PWM_STEPS + PASS_FULL / 2) / PASS_FULL);
    endfunction : scale_passed

endpackage : rssi_pwm_pkg

`default_nettype wire

// *** verilog/pwm_duty_if.sv ***
/*
 * Carrier between the duty control logic and the waveform generator.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface pwm_duty_if;
    logic [8:0] duty0;
    logic [8:0] duty1;
    logic wave0;
    logic wave1;

    modport ctrl (output duty0, output duty1, input wave0, input wave1);
    modport gen (input duty0, input duty1, output wave0, output wave1);
endinterface : pwm_duty_if

`default_nettype wire

// *** verilog/pwm_wave_gen.sv ***
/*
 * Two-channel waveform generator: 445 steps spread evenly over a 64 us period.
 * Assumes a synchronously released active-low reset from the parent.
 */
`default_nettype none

module pwm_wave_gen (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Duty in, waves out
    pwm_duty_if.gen pwm
);

    logic [12:0] acc_q, acc_d;
    logic [8:0] step_q, step_d;
    logic [8:0] lat0_q, lat0_d, lat1_q, lat1_d;
    logic wave0_d, wave1_d;

    ////////////////////////////////////////////////////////////////////////////
    // Fractional divider: exactly 445 step enables per 6400 cycles, so the
    // period is exact though a step is not a whole number of cycles
    always_comb begin
        logic [13:0] sum;
        logic step_en;
        sum = {1'b0, acc_q} + 14'(rssi_pwm_pkg::PWM_STEPS);
        step_en = sum >= 14'(rssi_pwm_pkg::PERIOD_CYCLES);
        acc_d = step_en ? 13'(sum - 14'(rssi_pwm_pkg::PERIOD_CYCLES)) : sum[12:0];
        step_d = step_q;
        lat0_d = lat0_q;
        lat1_d = lat1_q;
        if (step_en) begin
            if (step_q == 9'(rssi_pwm_pkg::PWM_STEPS - 1)) begin
                step_d = 9'h000;
                // Duty changes only at a period boundary, avoiding runt pulses
                lat0_d = pwm.duty0;
                lat1_d = pwm.duty1;
            end else begin
                step_d = step_q + 9'h001;
            end
        end
        wave0_d = step_q < lat0_q;
        wave1_d = step_q < lat1_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 13'h0000;
            step_q <= 9'h000;
            lat0_q <= 9'h000;
            lat1_q <= 9'h000;
            pwm.wave0 <= 1'b0;
            pwm.wave1 <= 1'b0;
        end else begin
            acc_q <= acc_d;
            step_q <= step_d;
            lat0_q <= lat0_d;
            lat1_q <= lat1_d;
            pwm.wave0 <= wave0_d;
            pwm.wave1 <= wave1_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [12:0] since_wrap_q;
    logic [8:0] prev_step_q;
    logic seen_wrap_q;
    logic wrap;
    // Previous step is kept in a flop; the wrap is the first cycle at step zero
    assign wrap = (step_q == 9'h000) && (prev_step_q != 9'h000);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            since_wrap_q <= 13'h0000;
            prev_step_q <= 9'h000;
            seen_wrap_q <= 1'b0;
        end else begin
            since_wrap_q <= wrap ? 13'h0001 : since_wrap_q + 13'h0001;
            prev_step_q <= step_q;
            seen_wrap_q <= seen_wrap_q | wrap;
        end
    end

    a_period_exact: assert property (wrap && seen_wrap_q |->
        since_wrap_q == 13'(rssi_pwm_pkg::PERIOD_CYCLES))
        else $error("pulse period is not 6400 cycles");

    a_step_bound: assert property (step_q < 9'(rssi_pwm_pkg::PWM_STEPS))
        else $error("step counter beyond 444");

    a_zero_duty_low: assert property (lat0_q == 9'h000 ##1 lat0_q == 9'h000
        |-> !pwm.wave0)
        else $error("wave high with zero duty");

endmodule : pwm_wave_gen

`default_nettype wire

// *** verif/pulse_meter.sv ***
/*
 * Pulse meter standing where an indicator or filter sits on a pulse output
 * pin. Assumes a push-pull pin registered on mclk, so no release level.
 */
`default_nettype none

module pulse_meter (
    // Clock
    input wire logic mclk,
    // Observed pin
    input wire logic pin,
    // Last high length and period in cycles, edge counts
    output int high_len,
    output int period_len,
    output int rises,
    output int falls
);
    timeunit 1ns;
    timeprecision 1ps;

    int run_hi = 0;
    int run_per = 0;
    logic pin_q = 1'b0;

    initial begin
        high_len = 0;
        period_len = 0;
        rises = 0;
        falls = 0;
    end

    // Lengths are counted in sampling edges, so they equal cycles of mclk
    always @(posedge mclk) begin
        if (pin && !pin_q) begin
            period_len = run_per;
            rises = rises + 1;
            run_per = 0;
        end
        run_per = run_per + 1;
        if (pin) begin
            run_hi = run_hi + 1;
        end else if (pin_q) begin
            high_len = run_hi;
            falls = falls + 1;
            run_hi = 0;
        end
        pin_q = pin;
    end
endmodule : pulse_meter

`default_nettype wire

// *** verif/rssi_pwm_output_tb.sv ***
/*
 * Self-checking bench for the strength and passed-value pulse outputs.
 * Assumes the package, carrier and design modules are compiled first.
 */
`default_nettype none

module rssi_pwm_output_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Short timer tick keeps the 100 ms based timers inside the run
    localparam int TICK = 40;

    logic mclk;
    logic rst_n;
    logic cmd_wr;
    logic [2:0] cmd_sel;
    logic [7:0] cmd_wdata;
    logic [2:0] cmd_rd_sel;
    logic [7:0] cmd_rdata;
    logic rx_pkt_valid;
    logic signed [7:0] rx_margin_db;
    logic io_pkt_valid;
    logic [9:0] io_value0;
    logic [9:0] io_value1;
    logic pulse_output_zero;
    logic pulse_output_one;
    logic [1:0] pins;
    int hi [2];
    int per [2];
    int ri [2];
    int fa [2];
    int fails = 0;
    int n_tests = 0;

    assign pins = {pulse_output_one, pulse_output_zero};

    rssi_pwm_output #(.TICK_CYCLES(TICK)) rssi_pwm_output_i (
        .mclk(mclk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata), .cmd_rd_sel(cmd_rd_sel), .cmd_rdata(cmd_rdata),
        .rx_pkt_valid(rx_pkt_valid), .rx_margin_db(rx_margin_db),
        .io_pkt_valid(io_pkt_valid), .io_value0(io_value0), .io_value1(io_value1),
        .pulse_output_zero(pulse_output_zero), .pulse_output_one(pulse_output_one));
    pulse_meter meter0_i (.mclk(mclk), .pin(pulse_output_zero), .high_len(hi[0]),
        .period_len(per[0]), .rises(ri[0]), .falls(fa[0]));
    pulse_meter meter1_i (.mclk(mclk), .pin(pulse_output_one), .high_len(hi[1]),
        .period_len(per[1]), .rises(ri[1]), .falls(fa[1]));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [2:0] sel, input logic [7:0] data);
        cmd_wr = 1'b1;
        cmd_sel = sel;
        cmd_wdata = data;
        tick(1);
        cmd_wr = 1'b0;
        // Let an edge pass so a following write never re-raises the strobe at once
        tick(1);
    endtask : wr

    task automatic rd(input logic [2:0] sel, input logic [7:0] exp, input string what);
        cmd_rd_sel = sel;
        tick(2);
        check(what, exp, cmd_rdata);
    endtask : rd

    task automatic rx(input logic signed [7:0] m);
        rx_pkt_valid = 1'b1;
        rx_margin_db = m;
        tick(1);
        rx_pkt_valid = 1'b0;
    endtask : rx

    task automatic io(input logic [9:0] v0, input logic [9:0] v1);
        io_pkt_valid = 1'b1;
        io_value0 = v0;
        io_value1 = v1;
        tick(1);
        io_pkt_valid = 1'b0;
    endtask : io

    // Bounded wait for the next rising or falling edge seen by a meter
    task automatic wait_edge(input int p, input bit rise);
        int c;
        int t;
        c = rise ? ri[p] : fa[p];
        t = 0;
        while ((rise ? ri[p] : fa[p]) == c && t < 7000) begin
            tick(1);
            t++;
        end
        if (t == 7000) begin
            fails++;
            $display("[ERR] pin %0d edge expected seen none", p);
        end
    endtask : wait_edge

    // Steps come from a fractional accumulator, so allow two cycles of spread
    task automatic measure(input int p, input int steps, input bit per_chk);
        int want;
        want = (steps * 6400 + 222) / 445;
        wait_edge(p, 1'b1);
        wait_edge(p, 1'b0);
        n_tests++;
        if (hi[p] < want - 2 || hi[p] > want + 2) begin
            fails++;
            $display("[ERR] high cycles pin %0d expected %0d seen %0d", p, want, hi[p]);
        end
        if (per_chk) begin
            wait_edge(p, 1'b1);
            n_tests++;
            if (per[p] != 6400) begin
                fails++;
                $display("[ERR] period cycles expected 6400 seen %0d", per[p]);
            end
        end
    endtask : measure

    task automatic hold_level(input logic [1:0] mask, input logic lvl, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            tick(1);
            if (((pins ^ {2{lvl}}) & mask) !== 2'b00) begin
                bad++;
            end
        end
        n_tests++;
        if (bad != 0) begin
            fails++;
            $display("[ERR] pins mask %b level %b expected 0 bad cycles seen %0d",
                mask, lvl, bad);
        end
    endtask : hold_level

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(rssi_pwm_pkg::SEL_TIMEOUT, 8'hFF, "timeout");
        rd(rssi_pwm_pkg::SEL_HOLD, 8'h28, "hold");
        rd(rssi_pwm_pkg::SEL_FUNC0, 8'h01, "func0");
        rd(rssi_pwm_pkg::SEL_FUNC1, 8'h00, "func1");
        wr(rssi_pwm_pkg::SEL_FUNC1, 8'h03);
        rd(rssi_pwm_pkg::SEL_FUNC1, 8'h00, "func1 bad code");
        wr(rssi_pwm_pkg::SEL_TIMEOUT, 8'h00);
        rd(rssi_pwm_pkg::SEL_TIMEOUT, 8'h00, "timeout low");
        hold_level(2'b11, 1'b0, 6500);
    endtask : t_reset

    task automatic t_rssi();
        wr(rssi_pwm_pkg::SEL_HOLD, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            rx(8'(10 * (i + 1)));
            measure(0, 182 + 76 * i, i == 1);
        end
        // With the last measure, this outlasts any finite hold since the 30 dB packet
        hold_level(2'b10, 1'b0, 6500);
        measure(0, 334, 1'b0);
    endtask : t_rssi

    task automatic t_hold();
        wr(rssi_pwm_pkg::SEL_HOLD, 8'h78);
        rx(8'hEC);
        measure(0, 5, 1'b0);
        // Hold ends within the measured period, so the next boundary latches zero
        tick(6400);
        hold_level(2'b01, 1'b0, 6500);
        rd(rssi_pwm_pkg::SEL_STATUS, 8'h04, "status");
    endtask : t_hold

    task automatic t_passed();
        wr(rssi_pwm_pkg::SEL_FUNC0, 8'h02);
        wr(rssi_pwm_pkg::SEL_FUNC1, 8'h02);
        wr(rssi_pwm_pkg::SEL_TIMEOUT, 8'hFF);
        io(10'h3FF, 10'h200);
        measure(1, 223, 1'b0);
        rd(rssi_pwm_pkg::SEL_STATUS, 8'h05, "status running");
        io(10'h3FF, 10'h200);
        tick(4000);
        io(10'h3FF, 10'h200);
        tick(1000);
        // Covers the latest drop that the first packet alone would cause
        hold_level(2'b01, 1'b1, 8400);
        tick(7300);
        hold_level(2'b11, 1'b0, 6500);
        rd(rssi_pwm_pkg::SEL_STATUS, 8'h04, "status expired");
    endtask : t_passed

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        cmd_wr = 1'b0;
        cmd_sel = 3'h0;
        cmd_wdata = 8'h00;
        cmd_rd_sel = 3'h0;
        rx_pkt_valid = 1'b0;
        rx_margin_db = 8'h00;
        io_pkt_valid = 1'b0;
        io_value0 = 10'h000;
        io_value1 = 10'h000;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        tick(2);
        t_reset();
        t_rssi();
        t_hold();
        t_passed();
        print_verdict();
    end

    // Scenarios need about 101k cycles; 120k cycles means a hang
    initial begin
        #1_200_000;
        fails++;
        print_verdict();
    end
endmodule : rssi_pwm_output_tb

`default_nettype wire
